// *** design/brc_pkg.sv ***
// Package: register map, field positions, reset values and timing counts for the reset/config latch
package brc_pkg;
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned SEQ_HALF_PERIODS   = 1024;
  localparam int unsigned SEQ_CYCLES         = SEQ_HALF_PERIODS / 2;
  localparam int unsigned LATCH_DELAY_CYCLES = 4;
  localparam int unsigned SYNC_MIN_CYCLES    = 2;

  localparam logic [11:0] OFS_SYSCFG   = 12'h000;
  localparam logic [11:0] OFS_LATCHCFG = 12'h004;
  localparam logic [11:0] OFS_BUSCFG0  = 12'h008;
  localparam logic [11:0] OFS_CMD      = 12'h00C;
  localparam logic [11:0] OFS_STATUS   = 12'h010;

  localparam int unsigned SYS_BIDIR_BIT  = 3;
  localparam int unsigned SYS_POWERDOWN_CONFIG_BIT_BIT = 5;
  localparam int unsigned SYS_BYTE_HIGH_DISABLE_BIT = 9;
  localparam int unsigned SYS_WRITE_CONFIG_FIELD_BIT  = 7;
  localparam int unsigned BC0_TYPE_LSB   = 6;
  localparam int unsigned BC0_LSTB_BIT   = 9;
  localparam int unsigned BC0_ACT_BIT    = 10;
  localparam int unsigned CMD_END_OF_INIT_INSTR_BIT  = 0;
  localparam int unsigned CMD_SWRST_BIT  = 1;
  localparam int unsigned CMD_WDRST_BIT  = 2;

  localparam logic [15:0] SYSCFG_RESET = 16'h0000;
  localparam logic [15:0] MASK_SOFT    = 16'h1FC0;
  localparam logic [15:0] MASK_SHORT   = 16'h1FFF;
  localparam logic [15:0] MASK_LONG    = 16'hFFFF;
  localparam logic [15:0] MASK_CLEAR   = 16'h003C;

  typedef enum logic [1:0] {
    BRC_KIND_SOFT  = 2'b00,
    BRC_KIND_SHORT = 2'b01,
    BRC_KIND_LONG  = 2'b11
  } brc_kind_t;

  typedef enum logic [2:0] {
    BRC_ST_RUN   = 3'b000,
    BRC_ST_SEQ   = 3'b001,
    BRC_ST_WAIT  = 3'b011,
    BRC_ST_LATCH = 3'b010,
    BRC_ST_INIT  = 3'b110
  } brc_state_t;
endpackage : brc_pkg

// *** design/brc_pin_sync.sv ***
// Three-stage pin synchroniser; level changes once stages two and three agree
`timescale 1ns/1ps
module brc_pin_sync import brc_pkg::*; (
  input  wire logic clk,    // Core clock
  input  wire logic rst_n,  // Async reset
  input  wire logic pin,    // Raw pin level
  output logic      level   // Filtered level
);
  logic [2:0] stage;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h7;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end
endmodule : brc_pin_sync

// *** design/brc_reset_ctrl.sv ***
// Reset pin handling, bidirectional reset and start-up configuration latch
`timescale 1ns/1ps
// Function
// - Reset output goes low at start of every reset kind.
// - Reset output stays low until end-of-init completes.
// - Bit 3 of system config enables bidirectional reset.
// - Every reset sequence clears the bidirectional enable bit.
// - Bidirectional enable may be set only before end-of-init.
// - Low powerdown pin during reset: stop pull, disable, go asynchronous.
// - With bidirectional enabled, pull reset input low for whole sequence.
// - Reset input drive released before first instruction fetch.
// - Bidirectional soft/watchdog resets become short hardware resets, re-latching bits 12..0.
// - Powerdown pin pull-down on exactly while reset input is low.
// - Power-down config bit enables powerdown pin pull-up after sequence.
// - Reset asynchronous if powerdown pin low, else synchronous.
// - Soft and watchdog resets sample config bits h4 down to l6 only.
// - Short hardware reset skips h7..h5; long and power-on sample all.
// - Config high byte copied into latched register low byte.
// - Latched bits routed to bus type, write config, clocks, ports, logic.
// - External access high sets bus active and latch strobe bits.
// - Internal sequence lasts 512 core clocks before pin is sampled.
// - Soft/watchdog resets without conversion clear config bits 5..2.
module brc_reset_ctrl import brc_pkg::*; (
  input  wire logic        CORE_CLK,        // 100 MHz core clock
  input  wire logic        RST_N,           // Power-on reset, async active low
  input  wire logic        RESET_IN_N_I,    // Reset input pin level
  output logic             RESET_IN_N_O,    // Reset input pin drive value
  output logic             RESET_IN_N_OE,   // Open-drain pull-down enable
  output logic             RESET_OUT_N,     // Reset output pin
  input  wire logic        PD_DELAY_HIGH,   // Powerdown pin above threshold
  output logic             PD_PULLDOWN_EN,  // Weak pull-down on powerdown pin
  output logic             PD_PULLUP_EN,    // Pull-up on powerdown pin
  input  wire logic [15:0] CONFIG_PORT,     // Configuration pins
  input  wire logic        EXT_ACCESS,      // External access pin
  output logic             CORE_RESET,      // Core held in reset
  output logic             ASYNC_RESET,     // Current reset is asynchronous
  output logic [2:0]       CLOCK_OPTION,    // To clock generator
  output logic [1:0]       SEGMENT_SEL,     // To port 4 logic
  output logic [1:0]       CHIP_SEL_COUNT,  // To port 6 logic
  output logic             BOOTSTRAP_SEL,   // Bootstrap select
  output logic             ADAPT_MODE,      // Adapt mode
  output logic             EMULATION_MODE,  // Emulation mode
  input  wire logic        S_AXI_ACLK_UNUSED, // Tie low; AXI uses CORE_CLK
  input  wire logic [11:0] S_AXI_AWADDR,    // Write address
  input  wire logic        S_AXI_AWVALID,   // Write address valid
  output logic             S_AXI_AWREADY,   // Write address ready
  input  wire logic [31:0] S_AXI_WDATA,     // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,     // Write strobes
  input  wire logic        S_AXI_WVALID,    // Write data valid
  output logic             S_AXI_WREADY,    // Write data ready
  output logic [1:0]       S_AXI_BRESP,     // Write response
  output logic             S_AXI_BVALID,    // Write response valid
  input  wire logic        S_AXI_BREADY,    // Write response ready
  input  wire logic [11:0] S_AXI_ARADDR,    // Read address
  input  wire logic        S_AXI_ARVALID,   // Read address valid
  output logic             S_AXI_ARREADY,   // Read address ready
  output logic [31:0]      S_AXI_RDATA,     // Read data
  output logic [1:0]       S_AXI_RRESP,     // Read response
  output logic             S_AXI_RVALID,    // Read data valid
  input  wire logic        S_AXI_RREADY     // Read data ready
);
  localparam logic [9:0] SEQ_LAST = 10'(SEQ_CYCLES - 1);
  localparam logic [2:0] LAT_LAST = 3'(LATCH_DELAY_CYCLES - 1);

  brc_state_t  state;
  brc_state_t  next_state;
  brc_kind_t   kind;
  logic [9:0]  seq_cnt;
  logic [2:0]  lat_cnt;
  logic [1:0]  low_cnt;
  logic [2:0]  own_tail;
  logic        rin_level;
  logic        pd_level;
  logic        bidir_en;
  logic        pwd_cfg;
  logic        init_done;
  logic        sw_req;
  logic        soft_conv;
  logic [15:0] latched;
  logic [7:0]  latched_cfg;
  logic        bus_act0;
  logic        lstb_ctl0;
  logic        hw_reset;
  logic        aw_hold;
  logic        w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_ok;

  function automatic logic [15:0] sample_mask(input brc_kind_t k);
    unique case (k)
      BRC_KIND_SOFT:  sample_mask = MASK_SOFT;
      BRC_KIND_SHORT: sample_mask = MASK_SHORT;
      BRC_KIND_LONG:  sample_mask = MASK_LONG;
      default:        sample_mask = MASK_LONG;
    endcase
  endfunction : sample_mask

  brc_pin_sync u_rin_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .pin   (RESET_IN_N_I),
    .level (rin_level)
  );

  brc_pin_sync u_pd_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .pin   (PD_DELAY_HIGH),
    .level (pd_level)
  );

  // External reset needs two filtered low cycles to count
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt <= 2'h0;
    end else if (rin_level) begin
      low_cnt <= 2'h0;
    end else if (low_cnt != 2'(SYNC_MIN_CYCLES)) begin
      low_cnt <= low_cnt + 2'h1;
    end
  end

  // Our own pull-down is not an external request
  assign hw_reset = (low_cnt == 2'(SYNC_MIN_CYCLES)) && !RESET_IN_N_OE;

  always_comb begin
    next_state = state;
    unique case (state)
      BRC_ST_RUN:   if (hw_reset || sw_req) next_state = BRC_ST_SEQ;
      BRC_ST_SEQ:   if (seq_cnt == SEQ_LAST) next_state = BRC_ST_WAIT;
      BRC_ST_WAIT:  if (rin_level) next_state = BRC_ST_LATCH;
      BRC_ST_LATCH: if (lat_cnt == LAT_LAST) next_state = BRC_ST_INIT;
      BRC_ST_INIT:  if (hw_reset || sw_req) next_state = BRC_ST_SEQ;
      default:      next_state = BRC_ST_SEQ;
    endcase
  end

  // Power-on enters the sequence directly as a long asynchronous reset
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= BRC_ST_SEQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seq_cnt <= 10'h000;
    end else if (state == BRC_ST_SEQ) begin
      seq_cnt <= seq_cnt + 10'h001;
    end else begin
      seq_cnt <= 10'h000;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lat_cnt <= 3'h0;
    end else if (state == BRC_ST_LATCH) begin
      lat_cnt <= lat_cnt + 3'h1;
    end else begin
      lat_cnt <= 3'h0;
    end
  end

  // Synchronised pin lags our own release; ignore that tail when judging long resets
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      own_tail <= 3'h0;
    end else if (RESET_IN_N_OE) begin
      own_tail <= 3'h5;
    end else if (own_tail != 3'h0) begin
      own_tail <= own_tail - 3'h1;
    end
  end

  // Kind tracking; a still-low pin after the sequence makes it long
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      kind      <= BRC_KIND_LONG;
      soft_conv <= 1'b0;
    end else if (next_state == BRC_ST_SEQ && state != BRC_ST_SEQ) begin
      kind      <= hw_reset ? BRC_KIND_SHORT : (bidir_en ? BRC_KIND_SHORT : BRC_KIND_SOFT);
      soft_conv <= !hw_reset && bidir_en;
    end else if (state == BRC_ST_WAIT && !rin_level && own_tail == 3'h0) begin
      kind <= BRC_KIND_LONG;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ASYNC_RESET <= 1'b1;
    end else if (next_state == BRC_ST_SEQ && state != BRC_ST_SEQ) begin
      ASYNC_RESET <= !pd_level;
    end else if ((state == BRC_ST_SEQ || state == BRC_ST_WAIT) && !rin_level && !pd_level) begin
      ASYNC_RESET <= 1'b1;
    end
  end

  // Pull-down only in the sequence; released before the latch and first fetch
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RESET_IN_N_OE <= 1'b0;
    end else if (next_state == BRC_ST_SEQ && state != BRC_ST_SEQ) begin
      RESET_IN_N_OE <= bidir_en && pd_level;
    end else if (state == BRC_ST_SEQ && next_state != BRC_ST_SEQ) begin
      RESET_IN_N_OE <= 1'b0;
    end else if (!pd_level) begin
      RESET_IN_N_OE <= 1'b0;
    end
  end
  assign RESET_IN_N_O = 1'b0;

  assign PD_PULLDOWN_EN = !rin_level;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RESET_OUT_N <= 1'b0;
    end else if (next_state == BRC_ST_SEQ) begin
      RESET_OUT_N <= 1'b0;
    end else if (state == BRC_ST_INIT && init_done) begin
      RESET_OUT_N <= 1'b1;
    end
  end

  assign CORE_RESET = (state == BRC_ST_SEQ) || (state == BRC_ST_WAIT) || (state == BRC_ST_LATCH);

  // Configuration latch at end of latch delay
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      latched <= 16'h0000;
    end else if (state == BRC_ST_LATCH && lat_cnt == LAT_LAST) begin
      latched <= (latched & ~sample_mask(kind) & ~((kind == BRC_KIND_SOFT) ? MASK_CLEAR : 16'h0000))
               | (CONFIG_PORT & sample_mask(kind));
    end
  end

  assign latched_cfg    = latched[15:8];
  assign CLOCK_OPTION   = latched[15:13];
  assign SEGMENT_SEL    = latched[12:11];
  assign CHIP_SEL_COUNT = latched[10:9];
  assign BOOTSTRAP_SEL  = latched[4];
  assign ADAPT_MODE     = latched[1];
  assign EMULATION_MODE = latched[0];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_act0  <= 1'b0;
      lstb_ctl0 <= 1'b0;
    end else if (state == BRC_ST_LATCH && lat_cnt == LAT_LAST) begin
      bus_act0  <= EXT_ACCESS;
      lstb_ctl0 <= EXT_ACCESS;
    end
  end

  // End-of-init, soft/watchdog requests
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_done <= 1'b0;
    end else if (CORE_RESET) begin
      init_done <= 1'b0;
    end else if (wr_fire && aw_addr == OFS_CMD && w_strb[0] && w_data[CMD_END_OF_INIT_INSTR_BIT]) begin
      init_done <= 1'b1;
    end
  end

  assign sw_req = wr_fire && aw_addr == OFS_CMD && w_strb[0] && !CORE_RESET &&
                  (w_data[CMD_SWRST_BIT] || w_data[CMD_WDRST_BIT]);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bidir_en <= 1'b0;
      pwd_cfg  <= 1'b0;
    end else if (CORE_RESET) begin
      bidir_en <= 1'b0;
      pwd_cfg  <= 1'b0;
    end else if (wr_fire && aw_addr == OFS_SYSCFG && w_strb[0]) begin
      if (!init_done) begin
        bidir_en <= w_data[SYS_BIDIR_BIT];
      end
      pwd_cfg <= w_data[SYS_POWERDOWN_CONFIG_BIT_BIT];
    end
  end

  assign PD_PULLUP_EN = pwd_cfg && !CORE_RESET;

  // AXI4-Lite write path: address and data taken in either order
  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold && !S_AXI_BVALID;
  assign wr_fire       = aw_hold && w_hold && !S_AXI_BVALID;
  assign wr_ok         = (aw_addr[1:0] == 2'h0) && (aw_addr <= OFS_STATUS);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold <= 1'b0;
      aw_addr <= 12'h000;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read path: one cycle after the address is taken
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= 2'h0;
      S_AXI_RDATA  <= 32'h0000_0000;
      unique case (S_AXI_ARADDR)
        OFS_SYSCFG: begin
          S_AXI_RDATA[SYS_BIDIR_BIT]  <= bidir_en;
          S_AXI_RDATA[SYS_POWERDOWN_CONFIG_BIT_BIT] <= pwd_cfg;
          S_AXI_RDATA[SYS_WRITE_CONFIG_FIELD_BIT]  <= latched[8];
          S_AXI_RDATA[SYS_BYTE_HIGH_DISABLE_BIT] <= !latched[7]; // Derived from bus width
        end
        OFS_LATCHCFG: S_AXI_RDATA[7:0] <= latched_cfg;
        OFS_BUSCFG0: begin
          S_AXI_RDATA[BC0_TYPE_LSB +: 2] <= latched[7:6];
          S_AXI_RDATA[BC0_LSTB_BIT]      <= lstb_ctl0;
          S_AXI_RDATA[BC0_ACT_BIT]       <= bus_act0;
        end
        OFS_CMD:    S_AXI_RDATA[CMD_END_OF_INIT_INSTR_BIT] <= init_done;
        OFS_STATUS: S_AXI_RDATA[7:0] <= {1'b0, state, kind, ASYNC_RESET, soft_conv};
        default:    S_AXI_RRESP <= 2'h2;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  property p_out_low_in_seq;
    @(posedge CORE_CLK) disable iff (!RST_N) (state == BRC_ST_SEQ) |-> !RESET_OUT_N;
  endproperty
  a_out_low_in_seq: assert property (p_out_low_in_seq) else $error("reset out high in sequence");

  property p_out_waits_init;
    @(posedge CORE_CLK) disable iff (!RST_N) $rose(RESET_OUT_N) |-> $past(init_done);
  endproperty
  a_out_waits_init: assert property (p_out_waits_init) else $error("reset out released early");

  property p_bidir_cleared;
    @(posedge CORE_CLK) disable iff (!RST_N) (state == BRC_ST_SEQ) |=> !bidir_en;
  endproperty
  a_bidir_cleared: assert property (p_bidir_cleared) else $error("bidir enable survived reset");

  property p_no_late_enable;
    @(posedge CORE_CLK) disable iff (!RST_N) init_done && !bidir_en |=> !bidir_en;
  endproperty
  a_no_late_enable: assert property (p_no_late_enable) else $error("bidir set after init");

  property p_pull_released;
    @(posedge CORE_CLK) disable iff (!RST_N) (state == BRC_ST_LATCH) |-> !RESET_IN_N_OE;
  endproperty
  a_pull_released: assert property (p_pull_released) else $error("pull-down held past sequence");

  property p_pd_pulldown;
    @(posedge CORE_CLK) disable iff (!RST_N) PD_PULLDOWN_EN == !rin_level;
  endproperty
  a_pd_pulldown: assert property (p_pd_pulldown) else $error("powerdown pull-down wrong");

  property p_seq_length;
    @(posedge CORE_CLK) disable iff (!RST_N) $rose(state == BRC_ST_SEQ) |-> (state == BRC_ST_SEQ)[*8] ##[1:600] (state == BRC_ST_WAIT);
  endproperty
  a_seq_length: assert property (p_seq_length) else $error("sequence length wrong");

  property p_soft_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (state == BRC_ST_LATCH && lat_cnt == LAT_LAST && kind == BRC_KIND_SOFT) |=> latched[5:2] == 4'h0;
  endproperty
  a_soft_mask: assert property (p_soft_mask) else $error("soft reset kept bits 5..2");

  c_conv: cover property (@(posedge CORE_CLK) disable iff (!RST_N) soft_conv && RESET_IN_N_OE);
  c_long: cover property (@(posedge CORE_CLK) disable iff (!RST_N) state == BRC_ST_LATCH && kind == BRC_KIND_LONG);
  c_soft: cover property (@(posedge CORE_CLK) disable iff (!RST_N) state == BRC_ST_LATCH && kind == BRC_KIND_SOFT);
endmodule : brc_reset_ctrl

// *** verif/brc_board.sv ***
// Board reset line model: pull-up with device open drain and external reset source
`timescale 1ns/1ps
module brc_board (
  input  wire logic dev_oe,   // Device pull-down enable
  input  wire logic dev_o,    // Device drive value
  input  wire logic ext_low,  // External source pulls low
  output logic      pin_level // Resolved line level
);
  // Pull-up wins only when nobody pulls low
  assign pin_level = !((dev_oe && !dev_o) || ext_low);
endmodule : brc_board

// *** verif/tb_top.sv ***
// Self-checking bench for the reset pin and start-up configuration latch
`timescale 1ns/1ps
module tb_top;
  import brc_pkg::*;
  logic        clk, rst_n, pin, oe, pin_o, ext_low, pd_high, rst_out_n, pd_pd, pd_pu, core_rst, async_rst;
  logic        boot, adapt, emu, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ext_acc;
  logic [15:0] cfg, lat;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, d;
  logic [2:0]  clk_opt;
  logic [1:0]  seg, cs, bresp, rresp, r;
  int          failures, check_count, cycles;

  brc_reset_ctrl i_brc_reset_ctrl (
    .CORE_CLK(clk), .RST_N(rst_n), .RESET_IN_N_I(pin), .RESET_IN_N_O(pin_o), .RESET_IN_N_OE(oe),
    .RESET_OUT_N(rst_out_n), .PD_DELAY_HIGH(pd_high), .PD_PULLDOWN_EN(pd_pd), .PD_PULLUP_EN(pd_pu),
    .CONFIG_PORT(cfg), .EXT_ACCESS(ext_acc), .CORE_RESET(core_rst), .ASYNC_RESET(async_rst),
    .CLOCK_OPTION(clk_opt), .SEGMENT_SEL(seg), .CHIP_SEL_COUNT(cs), .BOOTSTRAP_SEL(boot),
    .ADAPT_MODE(adapt), .EMULATION_MODE(emu), .S_AXI_ACLK_UNUSED(1'b0), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));

  brc_board i_brc_board (.dev_oe(oe), .dev_o(pin_o), .ext_low(ext_low), .pin_level(pin));

  always #5 clk = ~clk;

  // Five reset sequences of about 600 cycles each fit well below this ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] upd(input logic [15:0] o, n, m, c);
    return (o & ~m & ~c) | (n & m);
  endfunction : upd

  // Reads of ready see the value from before the edge, so each transfer lands on its own edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_p, w_p;
    aw_p = 1;
    w_p = 1;
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awr === 1) begin
        aw_p = 0;
        awv <= 0;
      end
      if (w_p && wr === 1) begin
        w_p = 0;
        wv <= 0;
      end
    end
    while (bv !== 1) @(posedge clk);
    br <= 0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do @(posedge clk); while (arr !== 1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1);
    v = rd;
    rs = rresp;
    rr <= 0;
    @(posedge clk);
  endtask : axi_rd

  task automatic wait_core(input logic lvl);
    while (core_rst !== lvl) @(posedge clk);
  endtask : wait_core

  task automatic check_lat;
    axi_rd(OFS_LATCHCFG, d, r);
    chk(d, {24'h0, lat[15:8]}, "latched config");
    chk({clk_opt, seg, cs, boot, adapt, emu}, {lat[15:9], lat[4], lat[1], lat[0]}, "routed bits");
  endtask : check_lat

  task automatic init_done;
    axi_wr(OFS_CMD, 32'h1);
    for (int i = 0; i < 8 && rst_out_n !== 1; i++) @(posedge clk);
    chk(rst_out_n, 1, "out released by end of init");
  endtask : init_done

  task automatic t_por;
    wait_core(0);
    lat = cfg;
    chk(rst_out_n, 0, "out low before end of init");
    check_lat();
    axi_rd(OFS_BUSCFG0, d, r);
    chk(d & 32'h0000_06C0, {21'h0, 2'b11, 1'b0, lat[7:6], 6'h00}, "bus cfg0");
    axi_rd(12'h3F0, d, r);
    chk(r, 2'b10, "unmapped read");
    axi_wr(12'h3F0, 32'h0);
    chk(bresp, 2'b10, "unmapped write");
    axi_wr(OFS_SYSCFG, 32'h28);
    axi_rd(OFS_SYSCFG, d, r);
    chk(d & 32'h28, 32'h28, "enable bits before end of init");
    chk(pd_pu, 1, "powerdown pull-up");
    init_done();
    $display("test por done");
  endtask : t_por

  task automatic t_soft_conv;
    cfg <= 16'h1234;
    axi_wr(OFS_CMD, 32'h2);
    wait_core(1);
    chk(rst_out_n, 0, "out low in soft reset");
    repeat (10) @(posedge clk);
    chk(oe, 1, "pull-down on");
    chk(pin, 0, "soft reset visible on line");
    chk(pd_pd, 1, "powerdown pull-down while line low");
    wait_core(0);
    chk(oe, 0, "pull-down off before run");
    lat = upd(lat, cfg, MASK_SHORT, 16'h0);
    check_lat();
    axi_rd(OFS_SYSCFG, d, r);
    chk(d[3], 0, "enable cleared by reset");
    $display("test converted soft reset done");
  endtask : t_soft_conv

  task automatic t_late_enable;
    init_done();
    axi_wr(OFS_SYSCFG, 32'h08);
    axi_rd(OFS_SYSCFG, d, r);
    chk(d[3], 0, "late enable ignored");
    $display("test late enable done");
  endtask : t_late_enable

  task automatic t_watchdog;
    cfg <= 16'h5A2C;
    axi_wr(OFS_CMD, 32'h4);
    wait_core(1);
    chk(rst_out_n, 0, "out low in watchdog reset");
    repeat (10) @(posedge clk);
    chk(oe, 0, "no pull-down without enable");
    wait_core(0);
    lat = upd(lat, cfg, MASK_SOFT, MASK_CLEAR);
    check_lat();
    $display("test watchdog reset done");
  endtask : t_watchdog

  task automatic t_hw_short;
    cfg <= 16'hC3E1;
    ext_acc <= 0;
    ext_low <= 1;
    repeat (8) @(posedge clk);
    chk(pd_pd, 1, "pull-down while line low");
    ext_low <= 0;
    wait_core(1);
    chk(rst_out_n, 0, "out low in short reset");
    repeat (10) @(posedge clk);
    chk(pd_pd, 0, "pull-down off while line high");
    wait_core(0);
    chk(async_rst, 0, "synchronous with pin high");
    lat = upd(lat, cfg, MASK_SHORT, 16'h0);
    check_lat();
    axi_rd(OFS_BUSCFG0, d, r);
    chk(d & 32'h0000_0600, 32'h0, "bus cfg0 with external access low");
    $display("test short hardware reset done");
  endtask : t_hw_short

  task automatic t_hw_long;
    pd_high <= 0;
    cfg <= 16'h7E18;
    ext_low <= 1;
    repeat (700) @(posedge clk);
    ext_low <= 0;
    wait_core(0);
    chk(async_rst, 1, "asynchronous with pin low");
    lat = upd(lat, cfg, MASK_LONG, 16'h0);
    check_lat();
    pd_high <= 1;
    $display("test long hardware reset done");
  endtask : t_hw_long

  initial begin
    clk = 0;
    rst_n = 0;
    ext_low = 0;
    pd_high = 1;
    ext_acc = 1;
    cfg = 16'hA5D3;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0000_0000;
    failures = 0;
    check_count = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_por();
    t_soft_conv();
    t_late_enable();
    t_watchdog();
    t_hw_short();
    t_hw_long();
    test_done();
  end
endmodule : tb_top
